// ==== directory_mode_tlb.sv ====
// Translation buffer controller for directory translation mode
// Function
// - Only instruction addresses use the buffer; channel addresses go straight to directory.
// - Instruction translation searches the buffer first; a hit returns the stored frame.
// - A miss translates through the processor storage directory entry for the page.
// - Make-addressable writes the page and its frame into the buffer.
// - Unmap searches the buffer for the page and invalidates a matching entry.
// - Reset and a control mode switch in table mode invalidate every entry.
// - No other whole or half buffer purge happens in table mode.
// - Translated versus untranslated operation never invalidates entries.
// - Flush instruction is an invalid operation in table mode, not a purge.
// - Supervisor state uses the upper half, problem state the lower half.
// - Directory index is address bits 8-20; result is frame then bits 21-31.
// - Unaddressable directory entry raises a page access exception, suppressing execution.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module directory_mode_tlb
  import tlb_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire logic [7:0]                 regAddr,
  input  wire logic [31:0]                regWrData,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [31:0]                regRdData,
  input  wire logic                       supervisorState,
  input  wire logic                       extendedControlMode,
  input  wire logic                       xlReq,
  input  wire logic [31:0]                xlVa,
  input  wire logic                       xlFromChannel,
  input  wire logic                       opMap,
  input  wire logic                       opUnmap,
  input  wire logic                       opFlush,
  input  wire logic [31:0]                opVa,
  input  wire logic [tlb_pkg::PAGE_W-1:0] opFrame,
  output logic                            busy,
  output logic                            xlDone,
  output logic      [tlb_pkg::PA_W-1:0]   xlPa,
  output logic                            xlHit,
  output logic                            xlExc,
  output logic                            opDone,
  output logic                            opInvalid,
  output logic                            dirReq,
  output logic      [tlb_pkg::PAGE_W-1:0] dirIndex,
  input  wire logic                       dirAck,
  input  wire logic [31:0]                dirData,
  output logic                            irq
);
  import tlb_pkg::*;

  tlb_array_if arrIf ();

  tlb_entry_array u_array (
    .ref_clk (ref_clk),
    .srst    (srst),
    .bus     (arrIf.arr)
  );

  tlb_usage_tracker u_usage (
    .ref_clk (ref_clk),
    .srst    (srst),
    .bus     (arrIf.lru)
  );

  state_e             stateReg;
  state_e             stateNext;
  op_e                opReg;
  logic [PAGE_W-1:0]  pageReg;
  logic [OFS_W-1:0]   ofsReg;
  logic [PAGE_W-1:0]  frameReg;
  logic               tableModeReg;
  logic               extSeenReg;
  logic [STAT_W-1:0]  statusReg;
  logic [STAT_W-1:0]  statusNext;
  logic [STAT_W-1:0]  irqEnReg;
  logic [STAT_W-1:0]  irqEnNext;
  logic [CNT_W-1:0]   hitCountReg;

  logic               idle;
  logic               flushTake;
  logic               mapTake;
  logic               unmapTake;
  logic               xlTake;
  logic               lookTake;
  logic               chanTake;
  logic               passTake;
  logic               modeSwitch;
  logic               probeXl;
  logic               doneHit;
  logic               dirDone;
  logic               pageExc;
  logic               badOp;
  logic               purgeAll;
  logic               xlDoneNext;
  logic [PA_W-1:0]    xlPaNext;
  logic               dirReqNext;
  logic [PAGE_W-1:0]  dirIndexNext;
  logic               wrCtrl;
  logic               wrIrqEn;
  logic               wrIrqClr;
  logic [STAT_W-1:0]  clrMask;
  logic [31:0]        readMux;

  // Request decode, one request taken per idle cycle: flush, map, unmap, translate
  assign idle      = (stateReg == ST_IDLE);
  assign flushTake = idle && opFlush;
  assign mapTake   = idle && !opFlush && opMap;
  assign unmapTake = idle && !opFlush && !opMap && opUnmap;
  assign xlTake    = idle && !opFlush && !opMap && !opUnmap && xlReq;
  assign chanTake  = xlTake && tableModeReg && xlFromChannel;
  assign passTake  = xlTake && !tableModeReg;
  assign lookTake  = mapTake || unmapTake || (xlTake && tableModeReg && !xlFromChannel);

  // A change of control mode is seen against the value held last cycle
  assign modeSwitch = tableModeReg && (extSeenReg != extendedControlMode);
  // Outside table mode the flush still purges; inside it is refused
  assign badOp      = flushTake && tableModeReg;
  assign purgeAll   = modeSwitch || (flushTake && !tableModeReg);

  assign probeXl  = (stateReg == ST_PROBE) && (opReg == OP_XLATE);
  assign doneHit  = probeXl && arrIf.hitReg;
  assign dirDone  = (stateReg == ST_DIR) && dirAck;
  assign pageExc  = dirDone && dirData[DIR_UNADDR];

  // Lookup port of the array, half chosen from the status word
  assign arrIf.lkValid = lookTake;
  assign arrIf.lkHalf  = supervisorState;
  assign arrIf.lkPage  = (mapTake || unmapTake) ? opVa[VA_PAGE_MSB:VA_PAGE_LSB]
                                                 : xlVa[VA_PAGE_MSB:VA_PAGE_LSB];
  assign arrIf.purge   = purgeAll;

  // Insert reuses a matching entry, otherwise the tracker's victim
  assign arrIf.wrEn    = (stateReg == ST_PROBE) && (opReg == OP_MAP);
  assign arrIf.wrIdx   = arrIf.hitReg ? arrIf.hitIdx : arrIf.victimIdx;
  assign arrIf.wrPage  = pageReg;
  assign arrIf.wrFrame = frameReg;
  assign arrIf.invEn   = (stateReg == ST_PROBE) && (opReg == OP_UNMAP) && arrIf.hitReg;
  assign arrIf.invIdx  = arrIf.hitIdx;
  assign arrIf.touchEn = doneHit || arrIf.wrEn;
  assign arrIf.touchIdx = arrIf.wrIdx;

  // Answer formation
  assign xlDoneNext   = doneHit || dirDone || passTake;
  assign xlPaNext     = doneHit  ? {arrIf.hitFrame, ofsReg} :
                        dirDone  ? {dirData[DIR_FRM_MSB:DIR_FRM_LSB], ofsReg} :
                        xlVa[PA_W-1:0];
  assign dirReqNext   = (probeXl && !arrIf.hitReg) || chanTake;
  assign dirIndexNext = chanTake ? xlVa[VA_PAGE_MSB:VA_PAGE_LSB] : pageReg;

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_IDLE: begin
        if (lookTake) begin
          stateNext = ST_PROBE;
        end else if (chanTake) begin
          stateNext = ST_DIR;
        end
      end
      ST_PROBE: begin
        stateNext = (probeXl && !arrIf.hitReg) ? ST_DIR : ST_IDLE;
      end
      ST_DIR: begin
        if (dirAck) begin
          stateNext = ST_IDLE;
        end
      end
      default: stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stateReg <= ST_IDLE;
      busy     <= 1'b0;
    end else begin
      stateReg <= stateNext;
      busy     <= (stateNext != ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      opReg    <= OP_XLATE;
      pageReg  <= '0;
      ofsReg   <= '0;
      frameReg <= '0;
    end else if (xlTake || mapTake || unmapTake) begin
      opReg    <= mapTake ? OP_MAP : (unmapTake ? OP_UNMAP : OP_XLATE);
      pageReg  <= arrIf.lkPage;
      ofsReg   <= xlVa[VA_OFS_MSB:0];
      frameReg <= opFrame;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      xlDone    <= 1'b0;
      xlPa      <= '0;
      xlHit     <= 1'b0;
      xlExc     <= 1'b0;
      opDone    <= 1'b0;
      opInvalid <= 1'b0;
      dirReq    <= 1'b0;
      dirIndex  <= '0;
    end else begin
      xlDone    <= xlDoneNext;
      xlPa      <= xlDoneNext ? xlPaNext : xlPa;
      xlHit     <= doneHit;
      xlExc     <= pageExc;
      opDone    <= ((stateReg == ST_PROBE) && !probeXl) || (flushTake && !tableModeReg);
      opInvalid <= badOp;
      dirReq    <= dirReqNext;
      dirIndex  <= dirReqNext ? dirIndexNext : dirIndex;
    end
  end

  // Register port
  assign wrCtrl   = regWr && (regAddr == REG_CTRL);
  assign wrIrqEn  = regWr && (regAddr == REG_IRQ_EN);
  assign wrIrqClr = regWr && (regAddr == REG_IRQ_CL);
  assign clrMask  = wrIrqClr ? regWrData[STAT_W-1:0] : '0;
  // Set wins over a clear in the same cycle so no event is lost
  assign statusNext = (statusReg & ~clrMask) | {purgeAll, badOp, pageExc};
  assign irqEnNext  = wrIrqEn ? regWrData[STAT_W-1:0] : irqEnReg;
  assign readMux = (regAddr == REG_CTRL)   ? {31'h0, tableModeReg} :
                   (regAddr == REG_STATUS) ? {29'h0, statusReg} :
                   (regAddr == REG_IRQ_EN) ? {29'h0, irqEnReg} :
                   (regAddr == REG_HITS)   ? {16'h0, hitCountReg} :
                   (regAddr == REG_VALID)  ? {16'h0, arrIf.validVec} :
                   32'h0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tableModeReg <= CTRL_RESET;
      extSeenReg   <= 1'b0;
      statusReg    <= STAT_RESET;
      irqEnReg     <= STAT_RESET;
      irq          <= 1'b0;
      hitCountReg  <= '0;
      regRdData    <= 32'h0;
    end else begin
      tableModeReg <= wrCtrl ? regWrData[CTRL_TABLE_BIT] : tableModeReg;
      extSeenReg   <= extendedControlMode;
      statusReg    <= statusNext;
      irqEnReg     <= irqEnNext;
      irq          <= |(statusNext & irqEnNext);
      hitCountReg  <= hitCountReg + CNT_W'(doneHit);
      regRdData    <= regRd ? readMux : 32'h0;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_CHAN_BYPASS: assert property (
    (xlTake && tableModeReg && xlFromChannel) |-> !arrIf.lkValid ##1 (stateReg == ST_DIR)
  ) else $error("channel address reached the buffer");

  AST_HIT_ANSWER: assert property (
    doneHit |=> xlDone && xlHit && (xlPa[PA_W-1:OFS_W] == $past(arrIf.hitFrame))
  ) else $error("hit not answered with stored frame");

  AST_MISS_WALK: assert property (
    (probeXl && !arrIf.hitReg) |=> dirReq && !xlDone && (dirIndex == $past(pageReg))
  ) else $error("miss did not go to directory");

  AST_MAP_WRITE: assert property (
    mapTake |=> arrIf.wrEn && (arrIf.wrPage == $past(opVa[VA_PAGE_MSB:VA_PAGE_LSB]))
             ##1 opDone
  ) else $error("insert not written");

  AST_UNMAP_CLEAR: assert property (
    (unmapTake ##1 arrIf.hitReg) |=> !arrIf.validVec[$past(arrIf.hitIdx)] && opDone
  ) else $error("unmapped entry still valid");

  AST_MODE_PURGE: assert property (
    modeSwitch |=> (arrIf.validVec == '0) && statusReg[ST_PURGED]
  ) else $error("mode switch did not purge");

  AST_NO_STRAY_PURGE: assert property (
    (tableModeReg && ($countones(arrIf.validVec) > 1) && !modeSwitch)
      |=> ($countones(arrIf.validVec) >= $countones($past(arrIf.validVec)) - 1)
  ) else $error("bulk invalidation in table mode");

  AST_PURGE_CAUSE: assert property (
    arrIf.purge |-> modeSwitch || (flushTake && !tableModeReg)
  ) else $error("purge without a cause");

  AST_FLUSH_REFUSED: assert property (
    (flushTake && tableModeReg) |=> opInvalid && !opDone && (arrIf.validVec == $past(arrIf.validVec))
  ) else $error("flush acted in table mode");

  AST_HALF_SELECT: assert property (
    arrIf.wrEn |-> (arrIf.wrIdx[IDX_W-1] == $past(supervisorState))
  ) else $error("insert in wrong half");

  AST_DIR_FORM: assert property (
    (dirDone && !dirData[DIR_UNADDR])
      |=> xlDone && !xlExc && (xlPa == {$past(dirData[DIR_FRM_MSB:DIR_FRM_LSB]), $past(ofsReg)})
  ) else $error("directory result badly formed");

  AST_PAGE_EXC: assert property (
    pageExc |=> xlExc && xlDone && !xlHit ##1 statusReg[ST_PAGE_EXC]
  ) else $error("page exception missing");

endmodule

// ==== directory_mode_tlb_tb.sv ====
// Self-checking bench for the directory mode translation buffer
`timescale 1ns/1ns
module directory_mode_tlb_tb;
  import tlb_pkg::*;
  logic              ref_clk, srst, regWr, regRd, xlReq, xlFromChannel, supervisorState;
  logic              extendedControlMode, opMap, opUnmap, opFlush, busy, xlDone, xlHit;
  logic              xlExc, opDone, opInvalid, dirReq, dirAck, irq, rdPrev, tbl;
  logic [7:0]        regAddr, dirLat;
  logic [31:0]       regWrData, regRdData, xlVa, opVa, dirData, seed, g;
  logic [PAGE_W-1:0] opFrame, dirIndex, mPage[16], mFrame[16], pg[9];
  logic [PA_W-1:0]   xlPa;
  logic [25:0]       xe, xlQ[$];
  logic [32:0]       rdQ[$];
  logic [1:0]        opQ[$];
  logic              mValid[16];
  int                miscompares, checked, cycles, hits, stamp, mUse[16];

  directory_mode_tlb uut (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .supervisorState(supervisorState), .extendedControlMode(extendedControlMode),
    .xlReq(xlReq), .xlVa(xlVa), .xlFromChannel(xlFromChannel), .opMap(opMap),
    .opUnmap(opUnmap), .opFlush(opFlush), .opVa(opVa), .opFrame(opFrame), .busy(busy),
    .xlDone(xlDone), .xlPa(xlPa), .xlHit(xlHit), .xlExc(xlExc), .opDone(opDone),
    .opInvalid(opInvalid), .dirReq(dirReq), .dirIndex(dirIndex), .dirAck(dirAck),
    .dirData(dirData), .irq(irq));
  directory_responder dirModel (.ref_clk(ref_clk), .srst(srst), .latency(dirLat),
    .dirReq(dirReq), .dirIndex(dirIndex), .dirAck(dirAck), .dirData(dirData));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int slotOf(logic sup, logic [PAGE_W-1:0] p);
    int b;
    b = sup ? 8 : 0;
    for (int i = b; i < b + 8; i++)
      if (mValid[i] && mPage[i] == p) return i;
    return -1;
  endfunction
  function automatic logic [31:0] validExp();
    logic [7:0] lo, hi;
    lo = 8'h00;
    hi = 8'h00;
    for (int i = 0; i < 8; i++) begin
      lo = lo + 8'(mValid[i]);
      hi = hi + 8'(mValid[i + 8]);
    end
    return {16'h0000, hi, lo};
  endfunction

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic endTest(string name);
    $display("test %s done", name);
  endtask

  always @(posedge ref_clk) begin
    if (++cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end
  // Result watcher: every answer takes the oldest note of its kind
  always @(posedge ref_clk) begin
    if (srst) begin
      rdPrev = 1'b0;
    end else begin
      g = regRdData;
      if (rdPrev && rdQ[0][32]) g = {g[31:16], 8'($countones(g[15:8])), 8'($countones(g[7:0]))};
      if (rdPrev) cmp("read data", rdQ.pop_front() & 33'h0FFFFFFFF, g);
      else cmp("idle read data", 32'h00000000, g);
      rdPrev = regRd;
      if (xlDone === 1'b1) begin
        xe = xlQ.size() > 0 ? xlQ.pop_front() : '1;
        cmp("translation", 32'(xe), 32'({xlExc, xlHit, xe[25] ? xe[23:0] : xlPa}));
      end
      if ((opDone | opInvalid) === 1'b1)
        cmp("op result", 32'(opQ.size() > 0 ? opQ.pop_front() : 2'h3), 32'({opInvalid, opDone}));
    end
  end

  task automatic waitIdle(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (busy !== 1'b0 && n < 60);
    if (n == 60) cmp("idle wait", 32'h0, 32'h1);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic popMode = 1'b0);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    rdQ.push_back({popMode, e});
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask
  task automatic xlate(logic [PAGE_W-1:0] p, logic chan, logic sup);
    int s, n;
    logic [31:0] d, r;
    logic [25:0] e;
    r = rnd();
    s = (tbl && !chan) ? slotOf(sup, p) : -1;
    d = {p[2:0] == 3'h7, 7'h00, p ^ 13'h0A5A, 11'h000};
    if (!tbl) e = {2'b00, p, r[10:0]};
    else if (s >= 0) e = {2'b01, mFrame[s], r[10:0]};
    else e = {d[31], 1'b0, d[23:11], r[10:0]};
    if (s >= 0) begin
      mUse[s] = ++stamp;
      hits++;
    end
    @(posedge ref_clk);
    xlVa <= {r[31:24], p, r[10:0]};
    xlFromChannel <= chan;
    supervisorState <= sup;
    dirLat <= {6'h00, r[13:12]};
    xlReq <= 1'b1;
    xlQ.push_back(e);
    @(posedge ref_clk);
    xlReq <= 1'b0;
    waitIdle(n);
    if (s >= 0) cmp("hit latency", 32'h2, 32'(n));
  endtask
  task automatic op(int k, logic [PAGE_W-1:0] p, logic [PAGE_W-1:0] f, logic sup);
    int s, b;
    logic [31:0] r;
    r = rnd();
    b = sup ? 8 : 0;
    s = slotOf(sup, p);
    if (k == 0) begin
      for (int i = b; i < b + 8; i++)
        if (s < 0 && !mValid[i]) s = i;
      if (s < 0) begin
        s = b;
        for (int i = b; i < b + 8; i++)
          if (mUse[i] < mUse[s]) s = i;
      end
      mPage[s] = p;
      mFrame[s] = f;
      mValid[s] = 1'b1;
      mUse[s] = ++stamp;
    end else if (k == 1 && s >= 0) mValid[s] = 1'b0;
    else if (k == 2 && !tbl) mValid = '{default: 1'b0};
    @(posedge ref_clk);
    opMap <= k == 0;
    opUnmap <= k == 1;
    opFlush <= k == 2;
    opVa <= {r[31:24], p, r[10:0]};
    opFrame <= f;
    supervisorState <= sup;
    opQ.push_back((k == 2 && tbl) ? 2'b10 : 2'b01);
    @(posedge ref_clk);
    opMap <= 1'b0;
    opUnmap <= 1'b0;
    opFlush <= 1'b0;
    waitIdle(s);
  endtask

  initial begin
    seed = 32'h00000032;
    {regWr, regRd, xlReq, xlFromChannel, supervisorState, extendedControlMode} = '0;
    {opMap, opUnmap, opFlush, tbl, regAddr, dirLat} = '0;
    {regWrData, xlVa, opVa, opFrame} = '0;
    {miscompares, checked, cycles, hits, stamp} = '0;
    mValid = '{default: 1'b0};
    srst = 1'b1;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0, a == 20);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0);
    wr(REG_IRQ_EN, 32'h7);
    rd(REG_IRQ_EN, 32'h7);
    wr(REG_IRQ_EN, 32'h0);
    endTest("registers");
    for (int i = 0; i < 4; i++) xlate(13'(rnd()), i[0], i[1]);
    op(2, 13'h0000, 13'h0000, 1'b0);
    endTest("pass through");
    wr(REG_CTRL, 32'h1);
    tbl = 1'b1;
    for (int i = 0; i < 9; i++) pg[i] = {1'b1, 8'(rnd()), 4'(i)};
    for (int i = 0; i < 3; i++) begin
      op(0, pg[i], 13'(rnd()), 1'b1);
      op(0, pg[i] ^ 13'h1000, 13'(rnd()), 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      xlate(pg[i], 1'b0, 1'b1);
      xlate(pg[i] ^ 13'h1000, 1'b0, 1'b0);
      xlate(pg[i], 1'b0, 1'b0);
      xlate(pg[i], 1'b1, 1'b1);
    end
    rd(REG_VALID, validExp(), 1'b1);
    endTest("map and half select");
    for (int i = 3; i < 8; i++) op(0, pg[i], 13'(rnd()), 1'b1);
    xlate(pg[0], 1'b0, 1'b1);
    op(0, pg[8], 13'(rnd()), 1'b1);
    op(0, pg[3], 13'(rnd()), 1'b1);
    for (int i = 0; i < 9; i++) xlate(pg[i], 1'b0, 1'b1);
    endTest("replacement");
    wr(REG_IRQ_CL, 32'h7);
    op(1, pg[2], 13'h0000, 1'b1);
    op(1, pg[1], 13'h0000, 1'b1);
    xlate(pg[2], 1'b0, 1'b1);
    op(2, 13'h0000, 13'h0000, 1'b1);
    wr(REG_CTRL, 32'h0);
    wr(REG_CTRL, 32'h1);
    rd(REG_VALID, validExp(), 1'b1);
    rd(REG_STATUS, 32'h2);
    endTest("unmap and refused flush");
    wr(REG_IRQ_CL, 32'h7);
    wr(REG_IRQ_EN, 32'h1);
    xlate(13'h0007, 1'b0, 1'b0);
    rd(REG_STATUS, 32'h1);
    cmp("irq", 32'h1, 32'(irq));
    wr(REG_IRQ_CL, 32'h1);
    rd(REG_STATUS, 32'h0);
    cmp("irq", 32'h0, 32'(irq));
    wr(REG_IRQ_EN, 32'h0);
    xlate(13'h000F, 1'b0, 1'b0);
    rd(REG_STATUS, 32'h1);
    cmp("irq", 32'h0, 32'(irq));
    endTest("interrupt");
    wr(REG_IRQ_CL, 32'h7);
    @(posedge ref_clk);
    extendedControlMode <= 1'b1;
    mValid = '{default: 1'b0};
    rd(REG_VALID, 32'h0, 1'b1);
    rd(REG_STATUS, 32'h4);
    xlate(pg[0], 1'b0, 1'b1);
    rd(REG_HITS, 32'(hits));
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(REG_VALID, 32'h0, 1'b1);
    endTest("purge events");
    repeat (2) @(posedge ref_clk);
    cmp("leftover", 32'h0, 32'(xlQ.size() + opQ.size() + rdQ.size()));
    close_out();
  end
endmodule

// ==== directory_responder.sv ====
// Behavioural processor storage directory answering the buffer's reads
`timescale 1ns/1ns
module directory_responder (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire logic [7:0]                 latency,
  input  wire logic                       dirReq,
  input  wire logic [tlb_pkg::PAGE_W-1:0] dirIndex,
  output logic                            dirAck,
  output logic      [31:0]                dirData
);
  import tlb_pkg::*;
  logic              pend;
  logic [7:0]        cnt;
  logic [PAGE_W-1:0] idx;
  logic [31:0]       junk;

  // Frame derived from the index; every eighth page is unaddressable
  function automatic logic [31:0] entryOf(input logic [PAGE_W-1:0] i);
    return {i[2:0] == 3'h7, 7'h00, i ^ 13'h0A5A, 11'h000};
  endfunction

  // Latency zero answers in the request cycle itself
  assign dirAck  = (dirReq && latency == 8'h00) || (pend && cnt == 8'h00);
  // Released bus keeps changing so a stale sample never looks right
  assign dirData = dirAck ? entryOf(pend ? idx : dirIndex) : junk;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend <= 1'b0;
      cnt  <= 8'h00;
      junk <= 32'hA5A50F0F;
    end else begin
      junk <= {junk[30:0], ~junk[31]};
      if (dirReq && latency != 8'h00) begin
        pend <= 1'b1;
        cnt  <= latency - 8'h01;
        idx  <= dirIndex;
      end else if (pend) begin
        if (cnt == 8'h00) pend <= 1'b0;
        else cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// ==== tlb_array_if.sv ====
// Carrier between the buffer controller, the entry array and the usage tracker
`timescale 1ns/1ns
interface tlb_array_if;
  import tlb_pkg::*;
  logic                    lkValid;
  logic                    lkHalf;
  logic [PAGE_W-1:0]       lkPage;
  logic                    hitReg;
  logic [IDX_W-1:0]        hitIdx;
  logic [PAGE_W-1:0]       hitFrame;
  logic [IDX_W-1:0]        victimIdx;
  logic [ENTRIES-1:0]      validVec;
  logic                    wrEn;
  logic [IDX_W-1:0]        wrIdx;
  logic [PAGE_W-1:0]       wrPage;
  logic [PAGE_W-1:0]       wrFrame;
  logic                    invEn;
  logic [IDX_W-1:0]        invIdx;
  logic                    purge;
  logic                    touchEn;
  logic [IDX_W-1:0]        touchIdx;

  modport ctrl (output lkValid, lkHalf, lkPage, wrEn, wrIdx, wrPage, wrFrame, invEn, invIdx,
                purge, touchEn, touchIdx,
                input hitReg, hitIdx, hitFrame, victimIdx, validVec);
  modport arr (input lkValid, lkHalf, lkPage, wrEn, wrIdx, wrPage, wrFrame, invEn, invIdx,
               purge, output hitReg, hitIdx, hitFrame, validVec);
  modport lru (input lkHalf, touchEn, touchIdx, validVec, output victimIdx);
endinterface

// ==== tlb_entry_array.sv ====
// Entry storage with parallel compare inside the selected half
`timescale 1ns/1ns
module tlb_entry_array
  import tlb_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  tlb_array_if.arr  bus
);
  logic [ENTRIES-1:0] validReg;
  logic [PAGE_W-1:0]  pageReg  [ENTRIES];
  logic [PAGE_W-1:0]  frameReg [ENTRIES];
  logic [ENTRIES-1:0] matchVec;
  logic [IDX_W-1:0]   matchIdx;

  genvar i;
  generate
    for (i = 0; i < ENTRIES; i++) begin : g_cmp
      localparam logic TOP = (i >= HALF_ENTRIES);
      assign matchVec[i] = validReg[i] && (pageReg[i] == bus.lkPage) && (TOP == bus.lkHalf);
    end
  endgenerate

  assign matchIdx     = firstIdx(matchVec);
  assign bus.validVec = validReg;

  always_ff @(posedge ref_clk) begin
    if (srst || bus.purge) begin
      validReg <= '0;
    end else begin
      if (bus.wrEn) begin
        validReg[bus.wrIdx] <= 1'b1;
      end
      if (bus.invEn) begin
        validReg[bus.invIdx] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (bus.wrEn) begin
      pageReg[bus.wrIdx]  <= bus.wrPage;
      frameReg[bus.wrIdx] <= bus.wrFrame;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus.hitReg   <= 1'b0;
      bus.hitIdx   <= '0;
      bus.hitFrame <= '0;
    end else begin
      bus.hitReg   <= bus.lkValid && (|matchVec);
      bus.hitIdx   <= matchIdx;
      bus.hitFrame <= frameReg[matchIdx];
    end
  end
endmodule

// ==== tlb_pkg.sv ====
// Shared constants, types and helpers for the directory mode translation buffer
package tlb_pkg;
  localparam int ENTRIES      = 16;
  localparam int HALF_ENTRIES = 8;
  localparam int IDX_W        = 4;
  localparam int PAGE_W       = 13;
  localparam int OFS_W        = 11;
  localparam int PA_W         = 24;
  localparam int AGE_W        = 3;
  localparam int CNT_W        = 16;
  localparam int STAT_W       = 3;
  // Bit 0 is the most significant bit in the printed numbering
  localparam int VA_PAGE_MSB  = 23;
  localparam int VA_PAGE_LSB  = 11;
  localparam int VA_OFS_MSB   = 10;
  localparam int DIR_FRM_MSB  = 23;
  localparam int DIR_FRM_LSB  = 11;
  localparam int DIR_UNADDR   = 31;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_EN = 8'h08;
  localparam logic [7:0] REG_IRQ_CL = 8'h0C;
  localparam logic [7:0] REG_HITS   = 8'h10;
  localparam logic [7:0] REG_VALID  = 8'h14;
  localparam int CTRL_TABLE_BIT = 0;
  localparam logic CTRL_RESET   = 1'b0;
  localparam int ST_PAGE_EXC = 0;
  localparam int ST_BAD_OP   = 1;
  localparam int ST_PURGED   = 2;
  localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;
  localparam logic [AGE_W-1:0] AGE_OLDEST  = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROBE = 2'b01,
    ST_DIR   = 2'b10
  } state_e;

  typedef enum logic [1:0] {
    OP_XLATE = 2'b00,
    OP_MAP   = 2'b01,
    OP_UNMAP = 2'b10
  } op_e;

  // Lowest set bit of a per-entry vector
  function automatic logic [IDX_W-1:0] firstIdx(input logic [ENTRIES-1:0] vec);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int k = ENTRIES - 1; k >= 0; k--) begin
      if (vec[k]) begin
        r = IDX_W'(k);
      end
    end
    return r;
  endfunction
endpackage

// ==== tlb_usage_tracker.sv ====
// Per-half age ordering that picks the entry to replace
`timescale 1ns/1ns
module tlb_usage_tracker
  import tlb_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  tlb_array_if.lru  bus
);
  logic [AGE_W-1:0]   ageReg [ENTRIES];
  logic [ENTRIES-1:0] freeVec;
  logic [ENTRIES-1:0] oldVec;
  logic               touchTop;

  assign touchTop = bus.touchIdx[IDX_W-1];

  genvar j;
  generate
    for (j = 0; j < ENTRIES; j++) begin : g_age
      localparam logic TOP = (j >= HALF_ENTRIES);
      assign freeVec[j] = !bus.validVec[j] && (TOP == bus.lkHalf);
      assign oldVec[j]  = (ageReg[j] == AGE_OLDEST) && (TOP == bus.lkHalf);
      // Ages in a half stay a permutation, so exactly one entry is oldest
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          ageReg[j] <= AGE_W'(j % HALF_ENTRIES);
        end else if (bus.touchEn && (IDX_W'(j) == bus.touchIdx)) begin
          ageReg[j] <= '0;
        end else if (bus.touchEn && (TOP == touchTop) && (ageReg[j] < ageReg[bus.touchIdx])) begin
          ageReg[j] <= ageReg[j] + AGE_W'(1);
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus.victimIdx <= '0;
    end else begin
      bus.victimIdx <= (|freeVec) ? firstIdx(freeVec) : firstIdx(oldVec);
    end
  end
endmodule
